// ==== core/pss_alu.sv ====
module pss_alu
  import pss_pkg::*;
(
  input  wire logic [5:0]    ic,     // operation code
  input  wire logic [DW-1:0] a,      // destination or tested operand
  input  wire logic [DW-1:0] b,      // source, immediate or mask
  input  wire logic          cy_in,  // carry flag before the operation
  output pss_alu_out_t       o       // result, write, skip and carry
);

  logic [3:0] lo;
  logic       cin;
  logic [4:0] ad;
  logic [4:0] sb;
  logic       arith;

  always_comb begin
    lo = ic[3:0];
    cin = cy_in & (lo[2:0] >= 3'h3) & (lo[2:0] <= 3'h5);
    ad = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    sb = {1'b0, a} - {1'b0, b} - {4'h0, cin};
    arith = 1'b0;
    o = '0;
    case (ic[5:4])
      2'h0, 2'h1: begin
        // binary 4-bit add/subtract and logic, result back to memory
        o.wr = 1'b1;
        case (lo)
          4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: begin
            o.res = ad[3:0];
            o.cy = ad[4];
            arith = 1'b1;
          end
          4'h6: o.res = a | b;
          4'h7: o.res = a & b;
          4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD: begin
            o.res = sb[3:0];
            o.cy = sb[4];
            arith = 1'b1;
          end
          4'hE: o.res = a ^ b;
          default: o.res = b;
        endcase
        o.cy_we = arith;
        if (arith && (lo[2:0] == 3'h1 || lo[2:0] == 3'h4)) begin
          o.skip = o.cy;
        end
        if (arith && (lo[2:0] == 3'h2 || lo[2:0] == 3'h5)) begin
          o.skip = ~o.cy;
        end
      end
      2'h2: begin
        case (lo)
          4'h0: o.skip = ((b & a) == a);
          4'h1: o.skip = ((b & a) == 4'h0);
          4'h2: o.skip = (a == b);
          4'h3: o.skip = (a != b);
          4'h4: begin
            o.res = b;
            o.wr = 1'b1;
          end
          4'h5: begin
            o.res = a;
            o.wr = 1'b1;
          end
          default: o.skip = 1'b0;
        endcase
      end
      default: begin
        // comparisons with immediate and multi-bit tests
        case (lo)
          4'h0: o.skip = (a < b);
          4'h1: o.skip = (a >= b);
          4'h2: o.skip = (a == b);
          4'h3: o.skip = (a != b);
          4'h4: o.skip = ((a & b) != b);
          4'h5: o.skip = ((a & b) == b);
          4'h6: o.skip = ((a & b) != 4'h0);
          4'h7: o.skip = ((a & b) == 4'h0);
          default: o.skip = 1'b0;
        endcase
      end
    endcase
  end

endmodule

// ==== core/pss_pkg.sv ====
package pss_pkg;

  localparam int PC_W    = 13;
  localparam int IW      = 16;
  localparam int DW      = 4;
  localparam int DMA_W   = 8;
  localparam int PORT_W  = 27;
  localparam int SEG_W   = 29;
  localparam int STK_N   = 2;

  localparam logic [PC_W-1:0] PC_RESET   = 13'h0000;
  localparam logic [PC_W-1:0] ROM_LAST   = 13'h1BFF;
  localparam logic [2:0]      CALL_PAGE  = 3'h1;
  localparam logic [2:0]      TABLE_PAGE = 3'h0;

  // instruction field positions
  localparam int IC_LSB   = 10;
  localparam int MADR_LSB = 4;
  localparam int C_LSB    = 0;
  localparam int TGT_W    = 10;

  // operation codes
  localparam logic [2:0] OP_JUMP_TOP = 3'h5;
  localparam logic [5:0] OP_CALL     = 6'h2F;
  localparam logic [5:0] OP_LD       = 6'h24;
  localparam logic [5:0] OP_TBL      = 6'h3E;
  localparam logic [5:0] OP_MISC     = 6'h3F;
  localparam logic [3:0] SUB_NOOP    = 4'h0;
  localparam logic [3:0] SUB_RET     = 4'h1;
  localparam logic [3:0] SUB_RETSKIP = 4'h2;
  localparam logic [3:0] SUB_HALT    = 4'h3;
  localparam logic [3:0] SUB_WAIT    = 4'h4;

  typedef enum logic [2:0] {
    ST_FETCH = 3'h0,
    ST_RD_M  = 3'h1,
    ST_RD_R  = 3'h3,
    ST_EXEC  = 3'h2,
    ST_HALT  = 3'h6
  } pss_state_t;

  typedef struct packed {
    logic [PORT_W-1:0] port;
    logic [SEG_W-1:0]  seg;
  } pss_pins_t;

  typedef struct packed {
    logic [DMA_W-1:0] addr;
    logic [DW-1:0]    wdata;
    logic             we;
  } pss_dm_req_t;

  typedef struct packed {
    logic [DW-1:0] res;
    logic          wr;
    logic          skip;
    logic          cy;
    logic          cy_we;
  } pss_alu_out_t;

  typedef struct packed {
    pss_state_t    st;
    logic [PC_W-1:0] pc;
    logic [IW-1:0] ir;
    logic [DW-1:0] mval;
    logic [DW-1:0] rval;
    logic          cy;
    logic [IW-1:0] dreg;
    pss_pins_t     pins;
    logic          single;
    logic          dflt;
  } pss_core_t;

  typedef struct packed {
    logic [STK_N-1:0][PC_W-1:0] ent;
  } pss_stack_t;

  localparam pss_core_t CORE_RESET = '{
    st: ST_FETCH, pc: PC_RESET, ir: 16'h0000, mval: 4'h0, rval: 4'h0,
    cy: 1'b0, dreg: 16'h0000, pins: '0, single: 1'b0, dflt: 1'b1};

  function automatic logic [5:0] ic_of(input logic [IW-1:0] w);
    return w[IC_LSB +: 6];
  endfunction

  function automatic logic [DMA_W-1:0] maddr_of(input logic [IW-1:0] w);
    return {2'h0, w[MADR_LSB +: 6]};
  endfunction

  function automatic logic [DMA_W-1:0] raddr_of(input logic [IW-1:0] w);
    return {4'h0, w[C_LSB +: 4]};
  endfunction

  function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] p,
                                              input logic [1:0]      n);
    return PC_W'(p + {11'h000, n});
  endfunction

endpackage

// ==== core/pss_sequencer.sv ====
// Overview of operation
// - a 13-bit up-counting program counter selects each fetched word
// - any system reset clears the program counter to address 0
// - a plain instruction advances the program counter by one
// - jump and call load the counter with the operand target address
// - a true skip condition advances the counter by two
// - a call pushes counter plus one into a 13-bit stack entry
// - plain return pops the newest stack entry into the counter; skipping return pops it plus one
// - the return stack holds two entries for two nesting levels
// - the ALU adds, subtracts, does logic, comparisons and multi-bit tests on 4 bits
// - no accumulator: operands come from data memory or the immediate field and results return to data memory
// - program memory is 7168 words of 16 bits, 0000H to 1BFFH, all jumpable
// - call targets lie only in page one, 400H to 7FFH
// - table load reads a 16-bit page-zero word into the data register
// - reset pin low holds reset; high starts execution at address 0
// - the clock-stop instruction halts the oscillator and all execution
// - reset makes ports inputs and returns the IF pin to frequency input
// - port latches are undefined after reset until software writes them
// - clock stop drives ports and segments low; single output keeps its latch
module pss_sequencer
  import pss_pkg::*;
(
  input  wire logic              clk,           // system clock
  input  wire logic              sys_rst,       // synchronous reset, active high
  input  wire logic              reset_pin_n,   // external reset pin, active low
  input  wire logic              hold_release,  // leaves oscillator halt
  output logic      [PC_W-1:0]   rom_addr,      // program memory address
  input  wire logic [IW-1:0]     rom_word,      // program memory word, same-cycle read
  output pss_dm_req_t            dm_req,        // data memory address, data and write
  input  wire logic [DW-1:0]     dm_rdata,      // data memory read data, same-cycle read
  output logic      [IW-1:0]     data_reg,      // table-load data register
  input  wire pss_pins_t         pin_latch,     // port and segment output latches
  input  wire logic              single_latch,  // dedicated single output latch
  output pss_pins_t              pin_out,       // port and segment pin levels
  output logic                   single_out,    // dedicated single output pin
  output logic                   osc_run,       // oscillator enable
  output logic                   pin_defaults,  // ports to input, IF pin to counter input
  output logic      [PC_W-1:0]   pc,            // program counter
  output logic                   carry          // carry or borrow flag
);

  pss_core_t    q;
  pss_core_t    d;
  pss_alu_out_t alu;
  logic         rst_core;
  logic [5:0]   ic;
  logic [3:0]   sub;
  logic [DW-1:0] op_a;
  logic [DW-1:0] op_b;
  logic         dest_r;
  logic         is_jump;
  logic         is_call;
  logic         is_ret;
  logic         is_retskip;
  logic         is_halt;
  logic         is_tbl;
  logic         in_exec;
  logic         push;
  logic         pop;
  logic [PC_W-1:0] stk_top;
  logic [PC_W-1:0] jump_tgt;
  logic [PC_W-1:0] call_tgt;
  logic [PC_W-1:0] table_addr;

  assign rst_core = sys_rst | ~reset_pin_n;

  // decode of the held instruction word
  always_comb begin
    ic = ic_of(q.ir);
    sub = q.ir[C_LSB +: 4];
    is_call = (ic == OP_CALL);
    // targets with top bits 111 would pass 1BFFH and decode as call instead
    is_jump = (ic[5:3] == OP_JUMP_TOP) && !is_call;
    is_ret = (ic == OP_MISC) && (sub == SUB_RET);
    is_retskip = (ic == OP_MISC) && (sub == SUB_RETSKIP);
    is_halt = (ic == OP_MISC) && (sub == SUB_HALT);
    is_tbl = (ic == OP_TBL);
    jump_tgt = q.ir[PC_W-1:0];
    call_tgt = {CALL_PAGE, q.ir[TGT_W-1:0]};
    table_addr = {TABLE_PAGE, q.ir[MADR_LSB +: 6], q.rval};
    dest_r = (ic[5:4] == 2'h1) || (ic == OP_LD);
    if (ic[5] == ic[4]) begin
      op_a = q.mval;
      op_b = q.ir[C_LSB +: 4];
    end else begin
      op_a = q.rval;
      op_b = q.mval;
    end
  end

  pss_alu u_alu (
    .ic    (ic),
    .a     (op_a),
    .b     (op_b),
    .cy_in (q.cy),
    .o     (alu)
  );

  assign in_exec = (q.st == ST_EXEC);
  assign push = in_exec & is_call;
  assign pop = in_exec & (is_ret | is_retskip);

  pss_stack u_stack (
    .clk  (clk),
    .rst  (rst_core),
    .push (push),
    .pop  (pop),
    .din  (pc_step(q.pc, 2'h1)),
    .top  (stk_top)
  );

  // memory address and write steering
  always_comb begin
    rom_addr = q.pc;
    dm_req = '0;
    case (q.st)
      ST_RD_M: dm_req.addr = maddr_of(q.ir);
      ST_RD_R: dm_req.addr = raddr_of(q.ir);
      ST_EXEC: begin
        if (is_tbl) begin
          rom_addr = table_addr;
        end
        dm_req.addr = dest_r ? raddr_of(q.ir) : maddr_of(q.ir);
        dm_req.wdata = alu.res;
        dm_req.we = alu.wr;
      end
      default: dm_req.addr = maddr_of(q.ir);
    endcase
  end

  always_comb begin
    d = q;
    d.dflt = 1'b0;
    // latches pass through as software left them; nothing initialises them here
    d.pins = pin_latch;
    d.single = single_latch;
    case (q.st)
      ST_FETCH: begin
        d.ir = rom_word;
        d.st = ST_RD_M;
      end
      ST_RD_M: begin
        d.mval = dm_rdata;
        d.st = ST_RD_R;
      end
      ST_RD_R: begin
        d.rval = dm_rdata;
        d.st = ST_EXEC;
      end
      ST_EXEC: begin
        if (alu.cy_we) begin
          d.cy = alu.cy;
        end
        if (is_tbl) begin
          d.dreg = rom_word;
        end
        if (is_jump) begin
          d.pc = jump_tgt;
        end else if (is_call) begin
          d.pc = call_tgt;
        end else if (is_ret) begin
          d.pc = stk_top;
        end else if (is_retskip) begin
          d.pc = pc_step(stk_top, 2'h1);
        end else if (alu.skip) begin
          d.pc = pc_step(q.pc, 2'h2);
        end else begin
          d.pc = pc_step(q.pc, 2'h1);
        end
        d.st = is_halt ? ST_HALT : ST_FETCH;
      end
      ST_HALT: begin
        d.pins = '0;
        if (hold_release) begin
          d.st = ST_FETCH;
        end
      end
      default: d.st = ST_FETCH;
    endcase
    if (d.st == ST_HALT) begin
      d.pins = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_core) begin
      q <= CORE_RESET;
    end else begin
      q <= d;
    end
  end

  assign osc_run = (q.st != ST_HALT);
  assign pin_out = q.pins;
  assign single_out = q.single;
  assign pin_defaults = q.dflt;
  assign data_reg = q.dreg;
  assign pc = q.pc;
  assign carry = q.cy;

endmodule

// ==== core/pss_stack.sv ====
module pss_stack
  import pss_pkg::*;
(
  input  wire logic            clk,    // system clock
  input  wire logic            rst,    // synchronous reset, active high
  input  wire logic            push,   // store a return address
  input  wire logic            pop,    // discard the newest entry
  input  wire logic [PC_W-1:0] din,    // return address to store
  output logic      [PC_W-1:0] top     // newest entry
);

  pss_stack_t q;
  pss_stack_t d;

  always_comb begin
    d = q;
    if (push) begin
      // a third nested call drops the oldest address
      d.ent[1] = q.ent[0];
      d.ent[0] = din;
    end else if (pop) begin
      d.ent[0] = q.ent[1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign top = q.ent[0];

endmodule

// ==== verification/pss_sequencer_bench.sv ====
module pss_sequencer_bench
  import pss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk = 0, sys_rst = 1, reset_pin_n = 1, hold_release = 0, single_latch = 0;
  logic [PC_W-1:0] rom_addr, pc;
  logic [IW-1:0]   rom_word, data_reg;
  logic [DW-1:0]   dm_rdata;
  pss_dm_req_t     dm_req;
  pss_pins_t       pin_latch = '0, pin_out;
  logic            single_out, osc_run, pin_defaults, carry;
  logic [IW-1:0]   rom [8192];
  logic [DW-1:0]   mem [256];
  logic [15:0]     rnd = 16'd34070;
  int              err_count = 0, n_tests = 0, ep = 0, stk[$];

  always #2.5 clk = ~clk;
  assign rom_word = rom[rom_addr];
  assign dm_rdata = mem[dm_req.addr];
  always @(posedge clk) if (dm_req.we) mem[dm_req.addr] <= dm_req.wdata;

  pss_sequencer dut (.clk, .sys_rst, .reset_pin_n, .hold_release, .rom_addr, .rom_word,
    .dm_req, .dm_rdata, .data_reg, .pin_latch, .single_latch, .pin_out, .single_out,
    .osc_run, .pin_defaults, .pc, .carry);

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task test_done;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // reference model of one instruction cycle
  task run1;
    logic [15:0] w;
    logic [5:0]  ic, m;
    logic [3:0]  r;
    int          s, nxt;
    w = rom[ep]; ic = w[15:10]; m = w[9:4]; r = w[3:0]; nxt = ep + 1; s = 0;
    if (w[15:13] == 3'h5 && ic != 6'h2F) nxt = w[12:0];
    else if (ic == 6'h2F) begin
      stk.push_back(ep + 1);
      nxt = 'h400 + w[9:0];
    end else if (ic == 6'h3F && r inside {4'h1, 4'h2}) nxt = stk.pop_back() + r - 1;
    else if (ic < 6'h02) begin
      s = mem[m] + r;
      if (ic == 6'h01 && s > 15) nxt = ep + 2;
    end else if (ic == 6'h3E) s = rom[{m, mem[r]}];
    repeat (4) @(negedge clk);
    check(pc, nxt);
    check(pin_out, pin_latch);
    check(pin_defaults, 0);
    if (ic < 6'h02) check(mem[m], s & 15);
    if (ic < 6'h02) check(carry, s > 15);
    if (ic == 6'h3E) check(data_reg, s);
    $display("instruction at %h done", ep);
    ep = nxt;
  endtask

  initial begin
    #50us;
    err_count++;
    test_done();
  end

  initial begin
    for (int i = 0; i < 8192; i++) rom[i] = 16'hFC00;
    for (int i = 5; i < 1024; i++) begin
      rnd = nx(rnd);
      rom[i] = rnd;
    end
    rom[0] = 16'h0053;
    rom[1] = 16'h046F;
    rom[2] = 16'hA003;
    rom[3] = 16'hBC10;
    rom['h410] = 16'hBC20;
    rom['h420] = 16'hFAA1;
    rom['h421] = 16'hFC02;
    rom['h412] = 16'hFC01;
    rom[4] = 16'hBBFF;
    rom['h1BFF] = 16'hFC03;
    for (int it = 0; it < 4; it++) begin
      for (int i = 0; i < 256; i++) begin
        rnd = nx(rnd);
        mem[i] = rnd[3:0];
      end
      pin_latch = {rnd[7:0], nx(rnd), rnd, nx(rnd)};
      single_latch = rnd[5];
      sys_rst = 1;
      repeat (10) @(negedge clk);
      check(pc, 0);
      check(pin_defaults, 1);
      sys_rst = 0;
      ep = 0;
      stk.delete();
      for (int k = 0; k < 12 && ep != 4; k++) run1();
      run1();
      repeat (4) @(negedge clk);
      check(osc_run, 0);
      repeat (2) @(negedge clk);
      check(pin_out, 0);
      check(single_out, single_latch);
      if (it[0]) begin
        hold_release = 1;
        for (int k = 0; k < 8 && !osc_run; k++) @(negedge clk);
        hold_release = 0;
        check(osc_run, 1);
      end
      reset_pin_n = 0;
      @(negedge clk);
      check(pc, 0);
      check(pin_defaults, 1);
      reset_pin_n = 1;
      $display("pass %0d done", it);
    end
    test_done();
  end
endmodule

// ==== verification/pss_sequencer_sva.sv ====
module pss_sequencer_chk
  import pss_pkg::*;
(
  input wire logic            clk,           // clock
  input wire logic            sys_rst,       // reset
  input wire logic            reset_pin_n,   // reset pin
  input wire logic            hold_release,  // halt exit
  input wire logic [PC_W-1:0] rom_addr,      // fetch address
  input wire pss_dm_req_t     dm_req,        // data memory request
  input wire pss_pins_t       pin_latch,     // pin latches
  input wire logic            single_latch,  // single latch
  input wire pss_pins_t       pin_out,       // pin levels
  input wire logic            single_out,    // single pin
  input wire logic            osc_run,       // oscillator on
  input wire logic [PC_W-1:0] pc,            // program counter
  input wire logic            carry          // carry flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !reset_pin_n);

  sequence s_pc_load;
    $changed(pc);
  endsequence
  sequence s_pc_hold;
    $stable(pc) [*3];
  endsequence

  a_pin_reset_pc: assert property (disable iff (sys_rst)
    !reset_pin_n |=> pc == PC_RESET && osc_run) else $error("pin reset left pc set");
  a_pc_cycle_len: assert property (s_pc_load |=> s_pc_hold)
    else $error("pc changed inside an instruction");
  a_fetch_at_pc: assert property ($changed(pc) |-> rom_addr == pc)
    else $error("fetch address differs from pc");
  a_write_gap: assert property (dm_req.we |=> !dm_req.we [*3])
    else $error("data write repeated within an instruction");
  a_carry_on_op: assert property ($changed(carry) |-> $past(dm_req.we))
    else $error("carry changed without an operation");
  a_halt_holds: assert property (!osc_run && !hold_release |=> !osc_run && $stable(pc))
    else $error("halted core moved");
  a_halt_wakes: assert property (!osc_run && hold_release |=> osc_run)
    else $error("halt not left on release");
  a_halt_pins_low: assert property (!osc_run && $past(!osc_run) |-> pin_out == '0)
    else $error("pins not low in halt");
  a_single_kept: assert property (!osc_run && $past(!osc_run)
    |-> single_out == $past(single_latch)) else $error("single output lost in halt");
endmodule

bind pss_sequencer pss_sequencer_chk u_chk (.clk, .sys_rst, .reset_pin_n, .hold_release,
  .rom_addr, .dm_req, .pin_latch, .single_latch, .pin_out, .single_out, .osc_run, .pc, .carry);
